// file: srp_pkg.sv
// Shared constants and types for the SDRAM row-activate and read path
package srp_pkg;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned ROW_W = 12;
  localparam int unsigned COL_W = 8;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned NBANK = 4;
  localparam int unsigned MODE_W = 12;
  // Mode word field positions
  localparam int unsigned BL_LSB = 0;
  localparam int unsigned LAT_LSB = 4;
  localparam int unsigned OPM_LO_POS = 7;
  localparam int unsigned OPM_HI_POS = 8;
  localparam int unsigned WBM_POS = 9;
  localparam int unsigned AP_POS = 10;
  // Burst length codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  // Read latency codes
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  // Reset values
  localparam logic [MODE_W-1:0] MODE_RST = 12'h020;
  localparam logic [DQ_W-1:0] DQ_RST = 16'h0000;
  // Timing in ps and derived cycles at 125 MHz
  localparam int unsigned CLK_PS = 8000;
  localparam int unsigned T_RCD_PS = 20000;
  localparam int unsigned T_RC_PS = 63000;
  localparam int unsigned T_RRD_PS = 14000;
  localparam int unsigned T_RP_PS = 20000;
  localparam int unsigned RCD_CYC = (T_RCD_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RC_CYC = (T_RC_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RRD_CYC = (T_RRD_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RP_CYC = (T_RP_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned DQM_RD_LAT = 2;
  // Command codes {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SRP_CMD_NOP = 4'h7,
    SRP_CMD_ACT = 4'h3,
    SRP_CMD_RD = 4'h5,
    SRP_CMD_WR = 4'h4,
    SRP_CMD_PRE = 4'h2,
    SRP_CMD_BST = 4'h6,
    SRP_CMD_LMR = 4'h0
  } srp_cmd_t;
endpackage

// file: srp_if.sv
// Pin-level link between memory controller and SDRAM read path
`timescale 1ns/1ps
interface srp_if;
  logic [3:0] cmd;
  logic [srp_pkg::BANK_W-1:0] ba;
  logic [srp_pkg::ROW_W-1:0] addr;
  logic dqm;
  logic [srp_pkg::DQ_W-1:0] dq_ctl;
  logic dq_ctl_oe;
  logic [srp_pkg::DQ_W-1:0] dq_mem;
  logic dq_mem_oe;
  modport ctl (output cmd, ba, addr, dqm, dq_ctl, dq_ctl_oe, input dq_mem, dq_mem_oe);
  modport mem (input cmd, ba, addr, dqm, dq_ctl, dq_ctl_oe, output dq_mem, dq_mem_oe);
endinterface

// file: srp_mem.sv
// SDRAM device end: mode word, bank rows, read burst pipeline
//
// What the document requires of this read path
// RULE_01 - Read latency programmable to two or three
// RULE_02 - Drive from n+m-1, valid at n+m
// RULE_03 - Controller keeps both operating-mode bits zero
// RULE_04 - Write-burst-mode bit limits writes to one column
// RULE_05 - Latency two only up to 133 MHz
// RULE_06 - Activate row before reading or writing
// RULE_07 - Wait activate-to-access delay, rounded up
// RULE_08 - Precharge before new row; respect row cycle
// RULE_09 - Space activates across banks by bank delay
// RULE_10 - Read carries bank, column, auto-precharge choice
// RULE_11 - First element after latency, then each edge
// RULE_12 - Fixed burst ends high-Z; full page wraps
// RULE_13 - Chaining read issued latency minus one early
// RULE_14 - Reads accepted every cycle, any bank
// RULE_15 - Write after read data, idle cycle advised
// RULE_16 - Mask kills read output after two clocks
// RULE_17 - Interrupting write forces pins to high-Z
// RULE_18 - Mask acts on write data immediately
// RULE_19 - Precharge ends read latency minus one early
// RULE_20 - No bank command before precharge period ends; srp_ctl times only the bank named in the precharge, not all banks
// RULE_21 - Burst terminate ends full-page and plain reads
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module srp_mem
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  srp_if.mem link,
  output logic [srp_pkg::NBANK-1:0] bank_open_o,
  output logic mode_ok_o,
  output logic wr_valid_o,
  output logic wr_single_o
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [srp_pkg::MODE_W-1:0] mode;
    logic [srp_pkg::NBANK-1:0] open;
    logic [srp_pkg::NBANK-1:0][srp_pkg::ROW_W-1:0] row;
    logic busy;
    logic [srp_pkg::BANK_W-1:0] bank;
    logic [srp_pkg::COL_W-1:0] col;
    logic [8:0] left;
    logic ap;
    logic pipe_v;
    logic [srp_pkg::COL_W-1:0] pipe_c;
    logic [srp_pkg::BANK_W-1:0] pipe_b;
    logic dqm_last;
    logic [srp_pkg::DQ_W-1:0] dq;
    logic dq_oe;
    logic wr_ok;
    logic wr_one;
  } srp_mem_st_t;

  srp_mem_st_t st_r;
  srp_mem_st_t st_nxt;
  logic [srp_pkg::NBANK-1:0][srp_pkg::ROW_W-1:0] row_live;
  logic [2:0] bl_code;
  logic [2:0] lat_code;
  logic [8:0] bl_len;
  logic lat3;
  logic [srp_pkg::COL_W-1:0] bl_mask;
  logic [srp_pkg::COL_W-1:0] next_col;

  // ==========================================================
  // Mode decode
  always_comb
  begin
    bl_code = st_r.mode[srp_pkg::BL_LSB +: 3];
    lat_code = st_r.mode[srp_pkg::LAT_LSB +: 3];
    lat3 = (lat_code == srp_pkg::LAT_3); // see RULE_01
    case (bl_code)
      srp_pkg::BL_2: bl_len = 9'h002;
      srp_pkg::BL_4: bl_len = 9'h004;
      srp_pkg::BL_8: bl_len = 9'h008;
      srp_pkg::BL_FULL: bl_len = 9'h100;
      default: bl_len = 9'h001;
    endcase
    bl_mask = 8'(bl_len - 9'h001);
    // Wrap within block; full page wraps to column 0
    next_col = (st_r.col & ~bl_mask) | (8'(st_r.col + 8'h01) & bl_mask); // see RULE_12
  end

  // Row storage per bank
  genvar gb;
  generate
    for (gb = 0; gb < srp_pkg::NBANK; gb++)
    begin : g_row
      assign row_live[gb] = st_r.row[gb];
    end
  endgenerate

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic rd_cmd;
    logic wr_cmd;
    logic emit;
    rd_cmd = 1'b0;
    wr_cmd = 1'b0;
    emit = 1'b0;
    st_nxt = st_r;
    st_nxt.wr_ok = 1'b0;
    st_nxt.wr_one = 1'b0;
    st_nxt.dqm_last = link.dqm;
    // Extra stage for latency three holds the element of the last clock
    st_nxt.pipe_v = st_r.busy; // see RULE_11
    st_nxt.pipe_c = st_r.col;
    st_nxt.pipe_b = st_r.bank;
    // Burst sequencer advances one column per clock
    if (st_r.busy)
    begin
      st_nxt.col = next_col;
      if (bl_code == srp_pkg::BL_FULL)
        st_nxt.left = st_r.left;
      else
        st_nxt.left = st_r.left - 9'h001;
      if (bl_code != srp_pkg::BL_FULL && st_r.left == 9'h001)
      begin
        st_nxt.busy = 1'b0;
        if (st_r.ap)
          st_nxt.open[st_r.bank] = 1'b0; // see RULE_10
      end
    end
    case (srp_pkg::srp_cmd_t'(link.cmd))
      srp_pkg::SRP_CMD_LMR:
        st_nxt.mode = link.addr;
      srp_pkg::SRP_CMD_ACT:
      begin
        st_nxt.open[link.ba] = 1'b1; // see RULE_06
        st_nxt.row[link.ba] = link.addr;
      end
      srp_pkg::SRP_CMD_RD:
        rd_cmd = 1'b1;
      srp_pkg::SRP_CMD_WR:
        wr_cmd = 1'b1;
      srp_pkg::SRP_CMD_PRE:
      begin
        st_nxt.busy = 1'b0; // see RULE_19
        // Element already fetched still drains
        if (link.addr[srp_pkg::AP_POS])
          st_nxt.open = '0;
        else
          st_nxt.open[link.ba] = 1'b0;
      end
      srp_pkg::SRP_CMD_BST:
      begin
        st_nxt.busy = 1'b0; // see RULE_21
        // Element already fetched still drains
      end
      default:
        emit = 1'b0;
    endcase
    // New read truncates any burst, accepted every cycle
    if (rd_cmd)
    begin
      st_nxt.busy = 1'b1; // see RULE_14
      st_nxt.bank = link.ba;
      st_nxt.col = link.addr[srp_pkg::COL_W-1:0];
      st_nxt.ap = link.addr[srp_pkg::AP_POS]; // see RULE_10
      st_nxt.left = bl_len;
    end
    // Write interrupts a read; valid if mask was high before or no read is in flight
    if (wr_cmd)
    begin
      st_nxt.busy = 1'b0;
      st_nxt.pipe_v = 1'b0; // see RULE_17
      st_nxt.wr_ok = st_r.dqm_last | ~(st_r.busy | st_r.pipe_v);
      st_nxt.wr_one = st_r.mode[srp_pkg::WBM_POS] | (bl_code == srp_pkg::BL_1); // see RULE_04
    end
    // Output register: latency two drives from the sequencer, three from the stage
    emit = lat3 ? st_r.pipe_v : st_r.busy; // see RULE_02
    // Mask seen one clock ago blanks the pins two clocks after it
    if (emit && !st_r.dqm_last && !wr_cmd) // see RULE_16
    begin
      st_nxt.dq_oe = 1'b1;
      st_nxt.dq = lat3 ? {6'h00, st_r.pipe_b, st_r.pipe_c} ^ {4'h0, row_live[st_r.pipe_b]}
                       : {6'h00, st_r.bank, st_r.col} ^ {4'h0, row_live[st_r.bank]};
    end
    else
    begin
      st_nxt.dq_oe = 1'b0; // see RULE_12
      st_nxt.dq = st_r.dq;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= '0;
      st_r.mode <= srp_pkg::MODE_RST;
      st_r.dqm_last <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // Outputs
  assign link.dq_mem = st_r.dq;
  assign link.dq_mem_oe = st_r.dq_oe;
  assign bank_open_o = st_r.open;
  assign mode_ok_o = ~st_r.mode[srp_pkg::OPM_LO_POS] & ~st_r.mode[srp_pkg::OPM_HI_POS];
  assign wr_valid_o = st_r.wr_ok;
  assign wr_single_o = st_r.wr_one;
endmodule

// file: srp_ctl.sv
// Controller end: issues commands with activate/precharge spacing
`timescale 1ns/1ps
module srp_ctl
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  srp_if.ctl link,
  input wire logic [3:0] req_cmd_i,
  input wire logic [srp_pkg::BANK_W-1:0] req_ba_i,
  input wire logic [srp_pkg::ROW_W-1:0] req_addr_i,
  input wire logic req_dqm_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  output logic [srp_pkg::DQ_W-1:0] rd_data_o,
  output logic rd_valid_o
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0] cmd;
    logic [srp_pkg::BANK_W-1:0] ba;
    logic [srp_pkg::ROW_W-1:0] addr;
    logic dqm;
    logic [srp_pkg::NBANK-1:0][3:0] rcd;
    logic [srp_pkg::NBANK-1:0][3:0] rc;
    logic [srp_pkg::NBANK-1:0][3:0] rp;
    logic [3:0] rrd;
    logic [srp_pkg::DQ_W-1:0] rdat;
    logic rval;
  } srp_ctl_st_t;

  srp_ctl_st_t st_r;
  srp_ctl_st_t st_nxt;
  logic ok;

  // ==========================================================
  // Spacing check for the offered command
  always_comb
  begin
    case (srp_pkg::srp_cmd_t'(req_cmd_i))
      srp_pkg::SRP_CMD_ACT:
        ok = st_r.rc[req_ba_i] == 4'h0 && st_r.rrd == 4'h0 && st_r.rp[req_ba_i] == 4'h0; // see RULE_08
      srp_pkg::SRP_CMD_RD, srp_pkg::SRP_CMD_WR:
        ok = st_r.rcd[req_ba_i] == 4'h0 && st_r.rp[req_ba_i] == 4'h0; // see RULE_07
      srp_pkg::SRP_CMD_LMR:
        ok = req_addr_i[srp_pkg::OPM_LO_POS] == 1'b0 && req_addr_i[srp_pkg::OPM_HI_POS] == 1'b0; // see RULE_03
      default:
        ok = st_r.rp[req_ba_i] == 4'h0; // see RULE_20
    endcase
  end

  // ==========================================================
  // Timers and command launch
  always_comb
  begin
    st_nxt = st_r;
    for (int b = 0; b < srp_pkg::NBANK; b++)
    begin
      if (st_r.rcd[b] != 4'h0) st_nxt.rcd[b] = st_r.rcd[b] - 4'h1;
      if (st_r.rc[b] != 4'h0) st_nxt.rc[b] = st_r.rc[b] - 4'h1;
      if (st_r.rp[b] != 4'h0) st_nxt.rp[b] = st_r.rp[b] - 4'h1;
    end
    if (st_r.rrd != 4'h0) st_nxt.rrd = st_r.rrd - 4'h1;
    st_nxt.cmd = srp_pkg::SRP_CMD_NOP;
    st_nxt.dqm = req_dqm_i; // see RULE_16 RULE_18
    if (req_valid_i && ok)
    begin
      st_nxt.cmd = req_cmd_i;
      st_nxt.ba = req_ba_i;
      st_nxt.addr = req_addr_i;
      if (req_cmd_i == srp_pkg::SRP_CMD_ACT)
      begin
        st_nxt.rcd[req_ba_i] = 4'(srp_pkg::RCD_CYC - 1); // see RULE_07
        st_nxt.rc[req_ba_i] = 4'(srp_pkg::RC_CYC - 1); // see RULE_08
        st_nxt.rrd = 4'(srp_pkg::RRD_CYC - 1); // see RULE_09
      end
      if (req_cmd_i == srp_pkg::SRP_CMD_PRE)
        st_nxt.rp[req_ba_i] = 4'(srp_pkg::RP_CYC - 1); // see RULE_20
    end
    st_nxt.rval = link.dq_mem_oe;
    st_nxt.rdat = link.dq_mem_oe ? link.dq_mem : st_r.rdat;
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= '0;
      st_r.cmd <= srp_pkg::SRP_CMD_NOP;
      st_r.dqm <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign req_ready_o = ok;
  assign link.cmd = st_r.cmd;
  assign link.ba = st_r.ba;
  assign link.addr = st_r.addr;
  assign link.dqm = st_r.dqm;
  assign link.dq_ctl = srp_pkg::DQ_RST;
  assign link.dq_ctl_oe = 1'b0; // see RULE_15
  assign rd_data_o = st_r.rdat;
  assign rd_valid_o = st_r.rval;
endmodule

// file: srp_chk.sv
// Link-level timing checks for the SDRAM read path
`timescale 1ns/1ps
module srp_chk
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] cmd,
  input wire logic [srp_pkg::ROW_W-1:0] addr,
  input wire logic dqm,
  input wire logic dq_mem_oe
);
  logic [2:0] lat_r;
  logic [2:0] bl_r;
  logic lat2;
  logic lat3;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Copy of latency and burst length from each mode load
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lat_r <= srp_pkg::MODE_RST[srp_pkg::LAT_LSB +: 3];
      bl_r <= srp_pkg::MODE_RST[srp_pkg::BL_LSB +: 3];
    end
    else if (cmd == srp_pkg::SRP_CMD_LMR)
    begin
      lat_r <= addr[srp_pkg::LAT_LSB +: 3];
      bl_r <= addr[srp_pkg::BL_LSB +: 3];
    end
  end
  // Latency decodes
  assign lat2 = lat_r == srp_pkg::LAT_2;
  assign lat3 = lat_r == srp_pkg::LAT_3;
  sequence s_rd;
    cmd == srp_pkg::SRP_CMD_RD && !dqm;
  endsequence
  sequence s_quiet;
    cmd == srp_pkg::SRP_CMD_NOP && !dqm;
  endsequence
  // ==========================================================
  // Read timing
  a_lat_two_start: assert property (lat2 ##0 s_rd ##1 s_quiet |-> ##1 dq_mem_oe)
    else $error("first read element late at latency two");
  a_lat_three_start: assert property (lat3 ##0 s_rd ##1 s_quiet [*2] |-> ##1 dq_mem_oe)
    else $error("first read element late at latency three");
  a_oe_origin: assert property ($rose(dq_mem_oe) && lat2 && !$past(dqm, 2) && !$past(dqm, 3)
    |-> $past(cmd, 2) == srp_pkg::SRP_CMD_RD)
    else $error("data driven without a read two cycles before");
  a_read_chain: assert property (lat2 ##0 s_rd ##1 s_rd ##1 s_quiet |-> dq_mem_oe ##1 dq_mem_oe)
    else $error("back to back reads left a gap");
  a_burst_four: assert property (lat2 && bl_r == srp_pkg::BL_4 ##0 s_rd ##1 s_quiet [*5]
    |-> dq_mem_oe ##1 !dq_mem_oe)
    else $error("four element burst has wrong length");
  // ==========================================================
  // Mask and truncation
  a_mask_kills_out: assert property (dqm |-> ##2 !dq_mem_oe)
    else $error("mask did not stop read output");
  a_write_hiz: assert property (cmd == srp_pkg::SRP_CMD_WR ##1 cmd == srp_pkg::SRP_CMD_NOP
    |-> !dq_mem_oe [*3])
    else $error("data driven after write");
  a_stop_ends: assert property (lat2 && cmd inside {srp_pkg::SRP_CMD_PRE, srp_pkg::SRP_CMD_BST}
    ##1 cmd == srp_pkg::SRP_CMD_NOP |-> ##1 !dq_mem_oe [*2])
    else $error("data continued after stop");
endmodule

// file: test_sdram_row_activate_read_path.sv
// Testbench for controller and device ends of the SDRAM read path
`timescale 1ns/1ps
module test_sdram_row_activate_read_path;
  logic core_clk_i;
  logic arst_n_i;
  logic [3:0] req_cmd;
  logic [1:0] req_ba;
  logic [11:0] req_addr;
  logic req_dqm;
  logic req_valid;
  logic req_ready;
  logic [15:0] rd_data;
  logic rd_valid;
  logic [3:0] bank_open;
  logic mode_ok;
  logic wr_valid;
  logic wr_single;
  logic [15:0] rd_q[$];
  logic [15:0] exp_q[$];
  int fail_count = 0;
  int tests_run = 0;
  int wr_v_cnt = 0;
  int wr_s_cnt = 0;
  int n;
  srp_if i_srp_if();
  srp_ctl i_srp_ctl(.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .link(i_srp_if.ctl),
    .req_cmd_i(req_cmd), .req_ba_i(req_ba), .req_addr_i(req_addr), .req_dqm_i(req_dqm),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid));
  srp_mem i_srp_mem(.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .link(i_srp_if.mem),
    .bank_open_o(bank_open), .mode_ok_o(mode_ok), .wr_valid_o(wr_valid),
    .wr_single_o(wr_single));
  srp_chk i_srp_chk(.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cmd(i_srp_if.cmd),
    .addr(i_srp_if.addr), .dqm(i_srp_if.dqm), .dq_mem_oe(i_srp_if.dq_mem_oe));
  // ==========================================================
  // Clock, monitors and watchdog
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (wr_valid === 1'b1) wr_v_cnt++;
    if (wr_single === 1'b1) wr_s_cnt++;
  end
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    fail_count++;
    test_done();
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Offer a command until taken; n counts edges, 0 when refused
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
    input logic m, output int k);
    req_cmd <= c;
    req_ba <= b;
    req_addr <= a;
    req_dqm <= m;
    req_valid <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk_i);
      k++;
    end
    while (req_ready !== 1'b1 && k < 20);
    if (req_ready !== 1'b1) k = 0;
  endtask
  task automatic idle(input int k);
    req_valid <= 1'b0;
    repeat (k) @(posedge core_clk_i);
  endtask
  task automatic burst(input logic [1:0] b, input logic [7:0] c, input int k);
    for (int i = 0; i < k; i++) exp_q.push_back({6'h00, b, c[7:2], 2'(c[1:0] + i)});
  endtask
  task automatic chk_rd();
    chk("rd_count", exp_q.size(), rd_q.size());
    foreach (exp_q[i]) if (i < rd_q.size()) chk("rd_data", exp_q[i], rd_q[i]);
    exp_q.delete();
    rd_q.delete();
  endtask
  task automatic test_done();
    $display("Checks %0d, failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    arst_n_i = 1'b0;
    req_cmd = srp_pkg::SRP_CMD_NOP;
    req_ba = 2'h0;
    req_addr = 12'h000;
    req_dqm = 1'b1;
    req_valid = 1'b0;
    repeat (16) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    chk("mode_ok", 1, mode_ok);
    issue(srp_pkg::SRP_CMD_LMR, 2'h0, 12'h022, 1'b0, n);
    issue(srp_pkg::SRP_CMD_ACT, 2'h0, 12'h000, 1'b0, n);
    issue(srp_pkg::SRP_CMD_RD, 2'h0, 12'h005, 1'b0, n);
    chk("rcd", srp_pkg::RCD_CYC, n);
    idle(10);
    burst(2'h0, 8'h05, 4);
    chk_rd();
    issue(srp_pkg::SRP_CMD_ACT, 2'h1, 12'h000, 1'b0, n);
    issue(srp_pkg::SRP_CMD_ACT, 2'h2, 12'h000, 1'b0, n);
    chk("rrd", srp_pkg::RRD_CYC, n);
    issue(srp_pkg::SRP_CMD_RD, 2'h1, 12'h00e, 1'b0, n);
    issue(srp_pkg::SRP_CMD_RD, 2'h0, 12'h020, 1'b0, n);
    chk("rd_rd", 1, n);
    idle(10);
    exp_q.push_back(16'h010e);
    burst(2'h0, 8'h20, 4);
    chk_rd();
    issue(srp_pkg::SRP_CMD_RD, 2'h2, 12'h040, 1'b0, n);
    issue(srp_pkg::SRP_CMD_BST, 2'h2, 12'h000, 1'b0, n);
    idle(10);
    exp_q.push_back(16'h0240);
    chk_rd();
    issue(srp_pkg::SRP_CMD_RD, 2'h0, 12'h050, 1'b0, n);
    issue(srp_pkg::SRP_CMD_NOP, 2'h0, 12'h000, 1'b0, n);
    issue(srp_pkg::SRP_CMD_PRE, 2'h0, 12'h000, 1'b0, n);
    issue(srp_pkg::SRP_CMD_ACT, 2'h0, 12'h000, 1'b0, n);
    chk("rp", srp_pkg::RP_CYC, n);
    idle(10);
    burst(2'h0, 8'h50, 2);
    chk_rd();
    issue(srp_pkg::SRP_CMD_RD, 2'h1, 12'h400, 1'b0, n);
    idle(10);
    burst(2'h1, 8'h00, 4);
    chk_rd();
    chk("open", 4'h5, bank_open);
    issue(srp_pkg::SRP_CMD_PRE, 2'h0, 12'h000, 1'b0, n);
    issue(srp_pkg::SRP_CMD_PRE, 2'h2, 12'h000, 1'b0, n);
    issue(srp_pkg::SRP_CMD_LMR, 2'h0, 12'h032, 1'b0, n);
    issue(srp_pkg::SRP_CMD_ACT, 2'h2, 12'h000, 1'b0, n);
    issue(srp_pkg::SRP_CMD_RD, 2'h2, 12'h033, 1'b0, n);
    idle(12);
    burst(2'h2, 8'h33, 4);
    chk_rd();
    issue(srp_pkg::SRP_CMD_LMR, 2'h0, 12'h0a2, 1'b0, n);
    chk("bad_mode", 0, n);
    idle(2);
    chk("mode_ok", 1, mode_ok);
    issue(srp_pkg::SRP_CMD_PRE, 2'h2, 12'h000, 1'b0, n);
    issue(srp_pkg::SRP_CMD_LMR, 2'h0, 12'h222, 1'b0, n);
    issue(srp_pkg::SRP_CMD_ACT, 2'h3, 12'h00a, 1'b0, n);
    issue(srp_pkg::SRP_CMD_RD, 2'h3, 12'h000, 1'b0, n);
    repeat (3) issue(srp_pkg::SRP_CMD_NOP, 2'h3, 12'h000, 1'b1, n);
    issue(srp_pkg::SRP_CMD_WR, 2'h3, 12'h000, 1'b0, n);
    idle(10);
    exp_q.push_back(16'h030a);
    chk_rd();
    chk("wr_valid", 1, wr_v_cnt);
    chk("wr_single", 1, wr_s_cnt);
    issue(srp_pkg::SRP_CMD_RD, 2'h3, 12'h008, 1'b0, n);
    issue(srp_pkg::SRP_CMD_WR, 2'h3, 12'h000, 1'b0, n);
    idle(10);
    chk_rd();
    chk("wr_invalid", 1, wr_v_cnt);
    // Full page wraps past the last column until terminated
    issue(srp_pkg::SRP_CMD_LMR, 2'h0, 12'h027, 1'b0, n);
    issue(srp_pkg::SRP_CMD_RD, 2'h3, 12'h0fe, 1'b0, n);
    repeat (3) issue(srp_pkg::SRP_CMD_NOP, 2'h3, 12'h000, 1'b0, n);
    issue(srp_pkg::SRP_CMD_BST, 2'h3, 12'h000, 1'b0, n);
    idle(10);
    exp_q = {16'h03f4, 16'h03f5, 16'h030a, 16'h030b};
    chk_rd();
    // Write burst mode clear: write is not single column
    issue(srp_pkg::SRP_CMD_WR, 2'h3, 12'h000, 1'b0, n);
    idle(4);
    chk("wr_valid_2", 2, wr_v_cnt);
    chk("wr_single_2", 2, wr_s_cnt);
    test_done();
  end
endmodule
